// [src/afe_map.svh]
`ifndef AFE_MAP_SVH
`define AFE_MAP_SVH

// ****************************************
// serial port framing
// ****************************************
`define AFE_ADDR_W 6
`define AFE_DATA_W 8
`define AFE_FRAME_W 14
`define AFE_READ_BIT 12
`define AFE_BITCNT_W 4
`define AFE_BITCNT_ONE 4'h1
`define AFE_BITCNT_MAX 4'hE

// ****************************************
// register addresses
// ****************************************
`define AFE_ADDR_MAIN 6'h01
`define AFE_ADDR_OUTPUT 6'h02
`define AFE_ADDR_CLAMP 6'h03
`define AFE_ADDR_SOFT_RST 6'h04
`define AFE_ADDR_CYC_RST 6'h05
`define AFE_ADDR_COLSEL 6'h06
`define AFE_ADDR_REV 6'h07
`define AFE_ADDR_SYNCDET 6'h08
`define AFE_ADDR_BLKDIS 6'h09
`define AFE_ADDR_DAC_R 6'h20
`define AFE_ADDR_DAC_G 6'h21
`define AFE_ADDR_DAC_B 6'h22
`define AFE_ADDR_DAC_ALL 6'h23
`define AFE_ADDR_GAIN_R 6'h28
`define AFE_ADDR_GAIN_G 6'h29
`define AFE_ADDR_GAIN_B 6'h2A
`define AFE_ADDR_GAIN_ALL 6'h2B
`define AFE_REG_COUNT 12

// ****************************************
// reset values
// ****************************************
`define AFE_DEF_MAIN 8'h03
`define AFE_DEF_OUTPUT 8'h20
`define AFE_DEF_CLAMP 8'h1F
`define AFE_DEF_ZERO 8'h00
`define AFE_DEF_DAC 8'h80
// arbitrary value, not tied to any part
`define AFE_REV_ID 8'h5A

// ****************************************
// field positions and mode values
// ****************************************
`define AFE_CDS_BIT 1
`define AFE_MONO_BIT 2
`define AFE_MAXSPD_BIT 6
`define AFE_CHAN_HI 7
`define AFE_CHAN_LO 6
`define AFE_CDSREF_HI 5
`define AFE_CDSREF_LO 4
`define AFE_LINESEQ_BIT 0
`define AFE_MAXSPD_SETUP 8'h45
`define AFE_CDSREF_ZERO 2'h0
`define AFE_CH_RED 2'h0
`define AFE_CH_GREEN 2'h1
`define AFE_CH_BLUE 2'h2

// ****************************************
// sampling timing in master clocks
// ****************************************
`define AFE_RATIO_FAST 8'h03
`define AFE_ADC_DIV_STD 2'h2
`define AFE_ADC_DIV_FAST 2'h3
`define AFE_RATIO_ONE 8'h01
`define AFE_RATIO_MAX 8'hFF

`endif

// [src/afe_pkg.sv]
package afe_pkg;

  // conversion sequencer, one-hot
  typedef enum logic [3:0] {
    AFE_CONV_IDLE = 4'h1,
    AFE_CONV_RED = 4'h2,
    AFE_CONV_GREEN = 4'h4,
    AFE_CONV_BLUE = 4'h8
  } afe_conv_state_t;

endpackage

// [src/afe_sync.sv]
module afe_sync #(
  parameter int WIDTH = 2
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // ****************************************
  // two-flop synchroniser, first stage read only here
  // ****************************************
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// [src/afe_mode_config.sv]
// How it works
// - max speed: ratio two, no double sampling
// - colour pixel mode converts red, green, blue
// - mono input chosen by clamp setup bits
// - six-bit serial addresses, main setup at one
// - sampling timing ignores double sampling setting
// - address then data, MSB first, load strobe
// - address bit four set starts read-back
// - writing soft reset restores all defaults
// - sample on first clock after sync low
`include "afe_map.svh"

module afe_mode_config (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic serial_load_strobe,
  output logic serial_out,
  input wire logic master_clk,
  input wire logic pixel_sync,
  output logic [7:0] main_setup,
  output logic [7:0] output_setup,
  output logic [7:0] clamp_channel_setup,
  output logic [7:0] colour_select_setup,
  output logic [7:0] sync_detect_setup,
  output logic [7:0] block_disable_setup,
  output logic [7:0] offset_dac_red,
  output logic [7:0] offset_dac_green,
  output logic [7:0] offset_dac_blue,
  output logic [7:0] gain_red,
  output logic [7:0] gain_green,
  output logic [7:0] gain_blue,
  output logic double_sampling_enable,
  output logic max_speed_select,
  output logic [1:0] mono_input_select,
  output logic line_sequential_colour,
  output logic [1:0] reset_sample_shift,
  output logic cycle_counter_clear,
  output logic sample_strobe,
  output logic conv_strobe,
  output logic [1:0] conv_channel,
  output logic [7:0] pixel_ratio,
  output logic config_error
);

  // ****************************************
  // register table
  // ****************************************
  localparam logic [5:0] REG_ADDR [`AFE_REG_COUNT] = '{
    `AFE_ADDR_MAIN, `AFE_ADDR_OUTPUT, `AFE_ADDR_CLAMP, `AFE_ADDR_COLSEL,
    `AFE_ADDR_SYNCDET, `AFE_ADDR_BLKDIS, `AFE_ADDR_DAC_R, `AFE_ADDR_DAC_G,
    `AFE_ADDR_DAC_B, `AFE_ADDR_GAIN_R, `AFE_ADDR_GAIN_G, `AFE_ADDR_GAIN_B
  };
  // broadcast address that also writes the entry
  localparam logic [5:0] REG_ALIAS [`AFE_REG_COUNT] = '{
    `AFE_ADDR_MAIN, `AFE_ADDR_OUTPUT, `AFE_ADDR_CLAMP, `AFE_ADDR_COLSEL,
    `AFE_ADDR_SYNCDET, `AFE_ADDR_BLKDIS, `AFE_ADDR_DAC_ALL,
    `AFE_ADDR_DAC_ALL, `AFE_ADDR_DAC_ALL, `AFE_ADDR_GAIN_ALL,
    `AFE_ADDR_GAIN_ALL, `AFE_ADDR_GAIN_ALL
  };
  localparam logic [7:0] REG_DEF [`AFE_REG_COUNT] = '{
    `AFE_DEF_MAIN, `AFE_DEF_OUTPUT, `AFE_DEF_CLAMP, `AFE_DEF_ZERO,
    `AFE_DEF_ZERO, `AFE_DEF_ZERO, `AFE_DEF_DAC, `AFE_DEF_DAC,
    `AFE_DEF_DAC, `AFE_DEF_ZERO, `AFE_DEF_ZERO, `AFE_DEF_ZERO
  };

  logic [`AFE_FRAME_W-1:0] link_sr_r;
  logic [`AFE_BITCNT_W-1:0] link_cnt_r;
  logic [7:0] link_out_r, rd_hold_r, rd_val, frame_data, mclk_cnt_r;
  logic [7:0] reg_r [`AFE_REG_COUNT];
  logic [5:0] frame_addr, rd_addr;
  logic [1:0] adc_cnt_r, adc_div, mono_chan;
  logic link_cnt_clr, sen_s, sen_d_r, sen_rise, wr_en, rd_en, soft_rst;
  logic mclk_s, ps_s, mclk_d_r, mclk_rise, ps_at_edge_r, sample_now;
  logic adc_tick, colour_pixel;
  afe_pkg::afe_conv_state_t conv_state_r;

  // ****************************************
  // input synchronisers
  // ****************************************
  afe_sync #(.WIDTH(1)) u_sen_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(serial_load_strobe),
    .sync_out(sen_s)
  );

  afe_sync #(.WIDTH(2)) u_clk_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in({master_clk, pixel_sync}),
    .sync_out({mclk_s, ps_s})
  );

  // ****************************************
  // link side: shift in, count, shift out
  // ****************************************
  always_ff @(posedge serial_clk or posedge reset) begin
    if (reset) begin
      link_sr_r <= '0;
    end else begin
      link_sr_r <= {link_sr_r[`AFE_FRAME_W-2:0], serial_in};
    end
  end

  // load strobe marks the frame boundary while the serial clock rests
  assign link_cnt_clr = reset | serial_load_strobe;

  always_ff @(posedge serial_clk or posedge link_cnt_clr) begin
    if (link_cnt_clr) begin
      link_cnt_r <= '0;
    end else if (link_cnt_r != `AFE_BITCNT_MAX) begin
      link_cnt_r <= link_cnt_r + `AFE_BITCNT_ONE;
    end
  end

  // read-back word is held steady since the previous load strobe
  always_ff @(negedge serial_clk or posedge reset) begin
    if (reset) begin
      link_out_r <= '0;
    end else if (link_cnt_r == `AFE_BITCNT_ONE) begin
      link_out_r <= rd_hold_r;
    end else begin
      link_out_r <= {link_out_r[6:0], 1'b0};
    end
  end

  assign serial_out = link_out_r[7];

  // ****************************************
  // frame commit in the system domain
  // ****************************************
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sen_d_r <= 1'b0;
    end else begin
      sen_d_r <= sen_s;
    end
  end

  // frame word is stable: the serial clock is idle around the strobe
  assign sen_rise = sen_s & ~sen_d_r;
  assign frame_addr = link_sr_r[`AFE_FRAME_W-1:`AFE_DATA_W];
  assign frame_data = link_sr_r[`AFE_DATA_W-1:0];
  assign wr_en = sen_rise & ~link_sr_r[`AFE_READ_BIT];
  assign rd_en = sen_rise & link_sr_r[`AFE_READ_BIT];
  assign rd_addr = {frame_addr[5], 1'b0, frame_addr[3:0]};
  assign soft_rst = wr_en && (frame_addr == `AFE_ADDR_SOFT_RST);

  // ****************************************
  // configuration registers
  // ****************************************
  for (genvar gi = 0; gi < `AFE_REG_COUNT; gi++) begin : g_reg
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        reg_r[gi] <= REG_DEF[gi];
      end else if (soft_rst) begin
        reg_r[gi] <= REG_DEF[gi];
      end else if (wr_en && (frame_addr == REG_ADDR[gi] ||
                             frame_addr == REG_ALIAS[gi])) begin
        reg_r[gi] <= frame_data;
      end
    end
  end

  always_comb begin
    rd_val = `AFE_DEF_ZERO;
    if (rd_addr == `AFE_ADDR_REV) begin
      rd_val = `AFE_REV_ID;
    end else begin
      for (int i = 0; i < `AFE_REG_COUNT; i++) begin
        if (rd_addr == REG_ADDR[i]) begin
          rd_val = reg_r[i];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_hold_r <= '0;
    end else if (rd_en) begin
      rd_hold_r <= rd_val;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cycle_counter_clear <= 1'b0;
    end else begin
      cycle_counter_clear <= wr_en && (frame_addr == `AFE_ADDR_CYC_RST);
    end
  end

  assign main_setup = reg_r[0];
  assign output_setup = reg_r[1];
  assign clamp_channel_setup = reg_r[2];
  assign colour_select_setup = reg_r[3];
  assign sync_detect_setup = reg_r[4];
  assign block_disable_setup = reg_r[5];
  assign offset_dac_red = reg_r[6];
  assign offset_dac_green = reg_r[7];
  assign offset_dac_blue = reg_r[8];
  assign gain_red = reg_r[9];
  assign gain_green = reg_r[10];
  assign gain_blue = reg_r[11];

  // ****************************************
  // mode decode
  // ****************************************
  assign max_speed_select = reg_r[0][`AFE_MAXSPD_BIT];
  assign double_sampling_enable = reg_r[0][`AFE_CDS_BIT] &
                                  ~max_speed_select;
  assign line_sequential_colour = reg_r[3][`AFE_LINESEQ_BIT];
  assign mono_input_select = reg_r[2][`AFE_CHAN_HI:`AFE_CHAN_LO];
  assign reset_sample_shift = reg_r[2][`AFE_CDSREF_HI:`AFE_CDSREF_LO];
  assign colour_pixel = ~reg_r[0][`AFE_MONO_BIT] & ~line_sequential_colour;
  // line-sequential colour runs through the red path only
  assign mono_chan = line_sequential_colour ? `AFE_CH_RED :
                     mono_input_select;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      config_error <= 1'b0;
    end else begin
      config_error <= (max_speed_select &&
                       reg_r[0] != `AFE_MAXSPD_SETUP) ||
                      (pixel_ratio == `AFE_RATIO_FAST &&
                       double_sampling_enable &&
                       reset_sample_shift != `AFE_CDSREF_ZERO);
    end
  end

  // ****************************************
  // sample point detection
  // ****************************************
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mclk_d_r <= 1'b0;
      ps_at_edge_r <= 1'b0;
    end else begin
      mclk_d_r <= mclk_s;
      if (mclk_rise) begin
        ps_at_edge_r <= ps_s;
      end
    end
  end

  assign mclk_rise = mclk_s & ~mclk_d_r;
  // independent of the double sampling bit
  assign sample_now = mclk_rise & ps_at_edge_r & ~ps_s;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sample_strobe <= 1'b0;
    end else begin
      sample_strobe <= sample_now;
    end
  end

  // master clocks per pixel, reported as the measured ratio
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mclk_cnt_r <= '0;
      pixel_ratio <= '0;
    end else if (sample_now) begin
      pixel_ratio <= mclk_cnt_r;
      mclk_cnt_r <= `AFE_RATIO_ONE;
    end else if (mclk_rise && mclk_cnt_r != `AFE_RATIO_MAX) begin
      mclk_cnt_r <= mclk_cnt_r + `AFE_RATIO_ONE;
    end
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  assign adc_div = (pixel_ratio == `AFE_RATIO_FAST) ? `AFE_ADC_DIV_FAST :
                   `AFE_ADC_DIV_STD;
  assign adc_tick = mclk_rise && (adc_cnt_r == adc_div - 2'h1);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      adc_cnt_r <= '0;
    end else if (sample_now || adc_tick) begin
      adc_cnt_r <= '0;
    end else if (mclk_rise) begin
      adc_cnt_r <= adc_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      conv_state_r <= afe_pkg::AFE_CONV_IDLE;
      conv_strobe <= 1'b0;
      conv_channel <= `AFE_CH_RED;
    end else begin
      conv_strobe <= 1'b0;
      case (conv_state_r)
        afe_pkg::AFE_CONV_IDLE, afe_pkg::AFE_CONV_BLUE: begin
          if (sample_now) begin
            conv_strobe <= 1'b1;
            conv_channel <= colour_pixel ? `AFE_CH_RED :
                            mono_chan;
            conv_state_r <= colour_pixel ? afe_pkg::AFE_CONV_RED :
                            afe_pkg::AFE_CONV_IDLE;
          end else if (adc_tick) begin
            conv_state_r <= afe_pkg::AFE_CONV_IDLE;
          end
        end
        afe_pkg::AFE_CONV_RED: begin
          if (adc_tick) begin
            conv_strobe <= 1'b1;
            conv_channel <= `AFE_CH_GREEN;
            conv_state_r <= afe_pkg::AFE_CONV_GREEN;
          end
        end
        afe_pkg::AFE_CONV_GREEN: begin
          if (adc_tick) begin
            conv_strobe <= 1'b1;
            conv_channel <= `AFE_CH_BLUE;
            conv_state_r <= afe_pkg::AFE_CONV_BLUE;
          end
        end
        default: begin
          conv_state_r <= afe_pkg::AFE_CONV_IDLE;
        end
      endcase
    end
  end

endmodule

// [bench/afe_mode_config_sva.sv]
module afe_mode_config_sva (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] main_setup,
  input wire logic [7:0] clamp_channel_setup,
  input wire logic [7:0] colour_select_setup,
  input wire logic double_sampling_enable,
  input wire logic max_speed_select,
  input wire logic [1:0] mono_input_select,
  input wire logic line_sequential_colour,
  input wire logic [1:0] reset_sample_shift,
  input wire logic sample_strobe,
  input wire logic conv_strobe,
  input wire logic [1:0] conv_channel,
  input wire logic config_error,
  input wire logic cycle_counter_clear
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  dsmp_map_a: assert property (
    double_sampling_enable == (main_setup[1] & ~main_setup[6]))
    else $error("double sampling enable wrong");
  maxspd_map_a: assert property (
    max_speed_select == main_setup[6])
    else $error("max speed select wrong");
  mono_map_a: assert property (
    mono_input_select == clamp_channel_setup[7:6])
    else $error("mono input select wrong");
  lineseq_map_a: assert property (
    line_sequential_colour == colour_select_setup[0])
    else $error("line sequential bit wrong");
  shift_map_a: assert property (
    reset_sample_shift == clamp_channel_setup[5:4])
    else $error("reset sample shift wrong");
  strobe_pair_a: assert property (
    sample_strobe |-> conv_strobe ##1 !sample_strobe)
    else $error("sample strobe not a single paired pulse");
  mono_conv_a: assert property (
    conv_strobe && main_setup[2] && !line_sequential_colour
    |-> conv_channel == mono_input_select)
    else $error("mono conversion on wrong channel");
  lineseq_red_a: assert property (
    conv_strobe && line_sequential_colour |-> conv_channel == 2'h0)
    else $error("line sequential conversion not red");
  colour_seq_a: assert property (
    sample_strobe && !main_setup[2] && !line_sequential_colour
    |-> conv_channel == 2'h0 ##[2:12] (conv_strobe && conv_channel == 2'h1))
    else $error("colour conversion order wrong");
  maxspd_err_a: assert property (
    (main_setup[6] && main_setup != 8'h45) [*2] |-> config_error)
    else $error("bad max speed setup not flagged");

  colour_cv_c: cover property (conv_strobe && conv_channel == 2'h2);
  cfg_err_c: cover property ($rose(config_error));
  clr_c: cover property (cycle_counter_clear);
endmodule

bind afe_mode_config afe_mode_config_sva u_sva (
  .ref_clk(ref_clk), .reset(reset), .main_setup(main_setup),
  .clamp_channel_setup(clamp_channel_setup),
  .colour_select_setup(colour_select_setup),
  .double_sampling_enable(double_sampling_enable),
  .max_speed_select(max_speed_select),
  .mono_input_select(mono_input_select),
  .line_sequential_colour(line_sequential_colour),
  .reset_sample_shift(reset_sample_shift),
  .sample_strobe(sample_strobe), .conv_strobe(conv_strobe),
  .conv_channel(conv_channel), .config_error(config_error),
  .cycle_counter_clear(cycle_counter_clear)
);

// [bench/afe_ctl_model.sv]
module afe_ctl_model (
  input wire logic ref_clk,
  input wire logic serial_out,
  output logic serial_clk,
  output logic serial_in,
  output logic serial_load_strobe,
  output logic master_clk,
  output logic pixel_sync
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    serial_clk = 1'b0;
    serial_in = 1'b0;
    serial_load_strobe = 1'b0;
    master_clk = 1'b0;
    pixel_sync = 1'b0;
  end

  // one 14-bit frame, link clock runs only inside it; rd gets read-back
  task automatic frame(input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] rd);
    logic [13:0] w;
    w = {a, d};
    rd = 8'h00;
    #3;
    for (int i = 13; i >= 0; i--) begin
      serial_in <= w[i];
      #7.5;
      if (i < 13 && i > 4) rd = {rd[6:0], serial_out};
      serial_clk <= 1'b1;
      #7.5;
      serial_clk <= 1'b0;
    end
    // released data line shows the inverse, not a held value
    serial_in <= ~w[0];
    @(posedge ref_clk);
    serial_load_strobe <= 1'b1;
    repeat (3) @(posedge ref_clk);
    serial_load_strobe <= 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask

  // 20 MHz master clock, sync pulse one clock wide every r clocks
  task automatic pixels(input int r, input int n);
    for (int p = 0; p < n; p++) begin
      for (int k = 0; k < r; k++) begin
        pixel_sync <= (k == 0);
        #25;
        master_clk <= 1'b1;
        #25;
        master_clk <= 1'b0;
      end
    end
    pixel_sync <= 1'b0;
  endtask
endmodule

// [bench/afe_mode_config_registers_tb_top.sv]
`include "afe_map.svh"

module afe_mode_config_registers_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, reset, serial_clk, serial_in, serial_load_strobe;
  logic serial_out, master_clk, pixel_sync, double_sampling_enable;
  logic max_speed_select, line_sequential_colour, cycle_counter_clear;
  logic sample_strobe, conv_strobe, config_error;
  logic [1:0] mono_input_select, reset_sample_shift, conv_channel;
  logic [7:0] main_setup, output_setup, clamp_channel_setup, pixel_ratio;
  logic [7:0] colour_select_setup, sync_detect_setup, block_disable_setup;
  logic [7:0] offset_dac_red, offset_dac_green, offset_dac_blue;
  logic [7:0] gain_red, gain_green, gain_blue, v;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  int n_smp = 0;
  int n_clr = 0;
  int n_cv[3] = '{0, 0, 0};

  afe_mode_config DUT (.*);
  afe_ctl_model u_ctl (.ref_clk(ref_clk), .serial_out(serial_out),
    .serial_clk(serial_clk), .serial_in(serial_in),
    .serial_load_strobe(serial_load_strobe), .master_clk(master_clk),
    .pixel_sync(pixel_sync));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (sample_strobe === 1'b1) n_smp++;
    if (conv_strobe === 1'b1 && conv_channel < 2'h3) n_cv[conv_channel]++;
    if (cycle_counter_clear === 1'b1) n_clr++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  // ****************************************
  // helpers and scenarios
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] x;
    u_ctl.frame(a, d, x);
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    u_ctl.frame(a | 6'h10, 8'h5A, d);
    u_ctl.frame(6'h3F, 8'h00, d);
  endtask

  task automatic t_defaults();
    logic [5:0] a[14] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h07, 6'h08,
      6'h09, 6'h0A, 6'h20, 6'h22, 6'h23, 6'h28, 6'h2B};
    logic [7:0] e[14] = '{8'h03, 8'h20, 8'h1F, 8'h00, 8'h00, `AFE_REV_ID,
      8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 14; i++) begin
      rd(a[i], v);
      chk(v, e[i]);
    end
  endtask

  task automatic t_access();
    logic [5:0] a[12] = '{6'h01, 6'h02, 6'h03, 6'h06, 6'h08, 6'h09,
      6'h20, 6'h21, 6'h22, 6'h28, 6'h29, 6'h2A};
    int c;
    for (int i = 0; i < 12; i++) wr(a[i], {2'h2, a[i]});
    for (int i = 0; i < 12; i++) begin
      rd(a[i], v);
      chk(v, {2'h2, a[i]});
    end
    wr(6'h07, 8'hFF);
    rd(6'h07, v);
    chk(v, `AFE_REV_ID);
    wr(6'h0A, 8'hFF);
    rd(6'h0A, v);
    chk(v, 8'h00);
    wr(6'h23, 8'h3C);
    wr(6'h2B, 8'hC3);
    chk(offset_dac_red, 8'h3C);
    chk(offset_dac_blue, 8'h3C);
    chk(gain_green, 8'hC3);
    chk(offset_dac_green, 8'h3C);
    chk(gain_red, 8'hC3);
    wr(6'h04, 8'hA5);
    chk(gain_red, 8'h00);
    chk(colour_select_setup, 8'h00);
    chk(block_disable_setup, 8'h00);
    chk(main_setup, 8'h03);
    chk(output_setup, 8'h20);
    chk(clamp_channel_setup, 8'h1F);
    chk(sync_detect_setup, 8'h00);
    chk(offset_dac_green, 8'h80);
    chk(gain_blue, 8'h00);
    c = n_clr;
    wr(6'h05, 8'h00);
    chk(8'(n_clr - c), 8'h01);
  endtask

  task automatic t_mode(input logic [7:0] m, cl, s, input int r,
                        input logic e, input int nr, ng, nb);
    int s0;
    int c0[3];
    wr(6'h01, m);
    wr(6'h03, cl);
    wr(6'h06, s);
    s0 = n_smp;
    c0 = n_cv;
    u_ctl.pixels(r, 4);
    repeat (12) @(posedge ref_clk);
    chk(pixel_ratio, 8'(r));
    chk(8'(n_smp - s0), 8'h04);
    chk(8'(n_cv[0] - c0[0]), 8'(4 * nr));
    chk(8'(n_cv[1] - c0[1]), 8'(4 * ng));
    chk(8'(n_cv[2] - c0[2]), 8'(4 * nb));
    chk({7'h00, config_error}, {7'h00, e});
    v = {5'h00, double_sampling_enable, max_speed_select,
      line_sequential_colour};
    chk(v, {5'h00, m[1] & ~m[6], m[6], s[0]});
    v = {4'h0, mono_input_select, reset_sample_shift};
    chk(v, {4'h0, cl[7:6], cl[5:4]});
  endtask

  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    t_defaults();
    t_access();
    t_mode(8'h03, 8'h1F, 8'h00, 6, 1'b0, 1, 1, 1);
    t_mode(8'h01, 8'h1F, 8'h00, 6, 1'b0, 1, 1, 1);
    t_mode(8'h07, 8'h9F, 8'h00, 6, 1'b0, 0, 0, 1);
    t_mode(8'h07, 8'h5F, 8'h01, 6, 1'b0, 1, 0, 0);
    t_mode(8'h07, 8'h1F, 8'h00, 3, 1'b1, 1, 0, 0);
    t_mode(8'h07, 8'h0F, 8'h00, 3, 1'b0, 1, 0, 0);
    t_mode(8'h45, 8'h1F, 8'h00, 2, 1'b0, 1, 0, 0);
    t_mode(8'h47, 8'h1F, 8'h00, 2, 1'b1, 1, 0, 0);
    t_mode(8'h03, 8'h1F, 8'h00, 8, 1'b0, 1, 1, 1);
    t_mode(8'h05, 8'h1F, 8'h00, 8, 1'b0, 1, 0, 0);
    complete_run();
  end
endmodule
